// ==== bench/exec_chk_sva.sv ====
`timescale 1ns/1ps
module exec_chk(input wire clk,reset,clk_en,instr_valid,zero_flag,file_we,
input wire [11:0] instr,input wire [7:0] acc,setup_reg,file_wdata,input wire [4:0] file_addr);
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire g=clk_en&&instr_valid,c0=g&&instr[11:5]==7'h10,c1=g&&instr[11:5]==7'h11;
wire s=g&&instr==12'h002,t=g&&instr[11:5]==7'h01;
property p_a; c1|=>file_we&&file_addr==$past(instr[4:0]); endproperty
a_a: assert property(p_a) else $error("addr");
property p_w; c0|=>!file_we&&zero_flag==(acc==8'h00); endproperty
a_w: assert property(p_w) else $error("acc");
property p_k; c1|=>$stable(acc); endproperty
a_k: assert property(p_k) else $error("keep");
property p_z; c1|=>zero_flag==(file_wdata==8'h00); endproperty
a_z: assert property(p_z) else $error("zero");
property p_s; s|=>setup_reg==$past(acc)&&$stable(zero_flag); endproperty
a_s: assert property(p_s) else $error("setup");
property p_t; t|=>file_we&&file_wdata==$past(acc)&&$stable(zero_flag); endproperty
a_t: assert property(p_t) else $error("store");
c_a: cover property(c1);
c_s: cover property(s);
c_t: cover property(t);
endmodule
bind move_and_config_instr_exec exec_chk exec_chk_i(.*);

// ==== bench/prog_mem.sv ====
`timescale 1ns/1ps
module prog_mem(input wire clk,input wire [11:0] w,output reg [11:0] instr=12'h000);
// Fetch lags the request by one falling edge
always @(negedge clk) instr<=w;
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
logic clk=0,reset=1,clk_en=0,instr_valid=0,zero_flag,file_we,ez=0,ew=0;
logic [11:0] w=0,instr,r=0;
logic [7:0] acc,setup_reg,file_wdata,ea=0,es=8'hFF,ewd=0,f[32];
logic [4:0] file_addr,eaddr=0;
int mismatches=0,checks=0;
always #2 clk=~clk;
prog_mem prog_mem_i(.*);
move_and_config_instr_exec move_and_config_instr_exec_i(.*);
// Reference model, fed from what the core really sees
always @(posedge clk) if(!reset&&clk_en) begin ew=0; if(instr_valid) casez(instr)
12'b0010_00??_????: begin ez=f[instr[4:0]]==8'h00; if(!instr[5]) ea=f[instr[4:0]];
  else begin ew=1; eaddr=instr[4:0]; ewd=f[instr[4:0]]; end end
12'hC??: ea=instr[7:0];
12'b0000_001?_????: begin f[instr[4:0]]=ea; ew=1; eaddr=instr[4:0]; ewd=ea; end
12'h002: es=ea;
endcase end
task give_verdict; if(mismatches==0&&checks>0) $display("Test passed");
else $display("Test failed"); $finish; endtask
task step(input [11:0] v); @(negedge clk); checks++; w<=v; clk_en<=!r[11]; instr_valid<=!r[10];
if({acc,setup_reg,zero_flag}!=={ea,es,ez}||$isunknown({acc,zero_flag})) begin mismatches++; $display("[FAIL] %0t state",$time); end
checks++;
if({file_we,file_addr,file_wdata}!=={ew,eaddr,ewd}) begin mismatches++; $display("[FAIL] %0t write",$time); end
endtask
initial begin #20000 mismatches++; give_verdict; end
// Files are filled first so no copy ever reads an unwritten entry
initial begin void'($urandom(32'h6114f86c)); repeat(20) @(negedge clk); reset=0; step(12'hC00);
for(int k=0;k<32;k++) step({7'h01,5'(k)});
step(12'h000);
repeat(3000) begin r=$urandom; case(r%5) 0: step({6'h08,r[5:0]}); 1: step({4'hC,r[7:0]});
2: step({7'h01,r[4:0]}); 3: step(12'h002); default: step(r&{12{r[9]}}); endcase end
give_verdict; end
endmodule

// ==== hdl/instr_exec_map.vh ====
`ifndef INSTR_EXEC_MAP_VH
`define INSTR_EXEC_MAP_VH

// ----------------------------------------
// Opcode patterns and masks
// ----------------------------------------
`define OP_COPY_FILE_MASK   12'hFC0
`define OP_COPY_FILE_PAT    12'h200
`define OP_LOAD_LIT_MASK    12'hF00
`define OP_LOAD_LIT_PAT     12'hC00
`define OP_STORE_MASK       12'hFE0
`define OP_STORE_PAT        12'h020
`define OP_NOP_WORD         12'h000
`define OP_LOAD_SETUP_WORD  12'h002

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLD_FILE_HI         4
`define FLD_FILE_LO         0
`define FLD_DEST_BIT        5
`define FLD_LIT_HI          7
`define FLD_LIT_LO          0

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define FILE_COUNT          32
`define ACC_RESET           8'h00
`define SETUP_RESET         8'hFF
`define ZERO_BYTE           8'h00
`define FLAG_RESET          1'b0
`define ADDR_RESET          5'h00

`endif

// ==== hdl/move_and_config_instr_exec.v ====
// Overview of operation
// (RQ1) A copy_file_entry word 0010_00df_ffff reads file register f (0..31) to its destination.
// (RQ2) With d clear the copied value goes into the accumulator.
// (RQ3) With d set the value is written back to file f and the accumulator is unchanged.
// (RQ4) copy_file_entry sets the zero flag from the moved value for either destination.
// (RQ5) Word 0000_0000_0010 copies the accumulator into the setup register in one cycle.
// (RQ6) load_literal_acc, store_acc_to_file and the all-zero no-op each take one cycle, no flags.
`timescale 1ns/1ps
`include "instr_exec_map.vh"

module move_and_config_instr_exec (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        reset,
    input  wire        clk_en,
    // Instruction from program memory
    input  wire [11:0] instr,
    input  wire        instr_valid,
    // Architectural state
    output reg  [7:0]  acc,
    output reg  [7:0]  setup_reg,
    output reg         zero_flag,
    // Last file write, for observation
    output reg         file_we,
    output reg  [4:0]  file_addr,
    output reg  [7:0]  file_wdata
);

// ----------------------------------------
// Operation classes
// ----------------------------------------
// One class per executed word; idle covers invalid and unknown words
localparam [2:0] OPC_IDLE  = 3'b000;
localparam [2:0] OPC_COPY  = 3'b001;
localparam [2:0] OPC_LIT   = 3'b010;
localparam [2:0] OPC_STORE = 3'b011;
localparam [2:0] OPC_SETUP = 3'b100;
localparam [2:0] OPC_NOP   = 3'b101;

// ----------------------------------------
// Field extraction
// ----------------------------------------
wire [4:0] f_sel;
wire       dest;
wire [7:0] literal;

assign f_sel   = instr[`FLD_FILE_HI:`FLD_FILE_LO];
assign dest    = instr[`FLD_DEST_BIT];
assign literal = instr[`FLD_LIT_HI:`FLD_LIT_LO];

// ----------------------------------------
// Pattern match
// ----------------------------------------
wire match_copy;
wire match_lit;
wire match_store;
wire match_setup;
wire match_nop;

assign match_copy  = ((instr & `OP_COPY_FILE_MASK) == `OP_COPY_FILE_PAT); // [RQ1]
assign match_lit   = ((instr & `OP_LOAD_LIT_MASK) == `OP_LOAD_LIT_PAT);   // [RQ6]
assign match_store = ((instr & `OP_STORE_MASK) == `OP_STORE_PAT);        // [RQ6]
assign match_setup = (instr == `OP_LOAD_SETUP_WORD);                     // [RQ5]
assign match_nop   = (instr == `OP_NOP_WORD);                            // [RQ6]

// ----------------------------------------
// Class select
// ----------------------------------------
// The patterns never overlap, so the order below is for reading only
reg [2:0] op_class;

always @* begin
    op_class = OPC_IDLE;
    if (instr_valid) begin
        if (match_copy) begin
            op_class = OPC_COPY;
        end else if (match_lit) begin
            op_class = OPC_LIT;
        end else if (match_store) begin
            op_class = OPC_STORE;
        end else if (match_setup) begin
            op_class = OPC_SETUP;
        end else if (match_nop) begin
            op_class = OPC_NOP;
        end
    end
end

// ----------------------------------------
// File registers
// ----------------------------------------
// No reset on the array: contents are undefined at power-up, as in the core
reg  [7:0] file_mem [0:`FILE_COUNT-1];
wire [7:0] file_rd;

// Copy reads before the write-back of the same edge lands
assign file_rd = file_mem[f_sel]; // [RQ1]

// ----------------------------------------
// Write-back steering
// ----------------------------------------
wire wb_acc_from_file;
wire wb_acc_from_lit;
wire wb_file_from_file;
wire wb_file_from_acc;
wire wb_setup;
wire wb_flag;

assign wb_acc_from_file  = (op_class == OPC_COPY) && !dest; // [RQ2]
assign wb_file_from_file = (op_class == OPC_COPY) && dest;  // [RQ3]
assign wb_flag           = (op_class == OPC_COPY);          // [RQ4]
assign wb_setup          = (op_class == OPC_SETUP);         // [RQ5]
assign wb_acc_from_lit   = (op_class == OPC_LIT);           // [RQ6]
assign wb_file_from_acc  = (op_class == OPC_STORE);         // [RQ6]

// ----------------------------------------
// Next state
// ----------------------------------------
// Everything holds by default; file_we is a one-cycle pulse
reg [7:0] next_acc;
reg [7:0] next_setup_reg;
reg       next_zero_flag;
reg       next_file_we;
reg [4:0] next_file_addr;
reg [7:0] next_file_wdata;

always @* begin
    next_acc        = acc;
    next_setup_reg  = setup_reg;
    next_zero_flag  = zero_flag;
    next_file_we    = 1'b0;
    next_file_addr  = file_addr;
    next_file_wdata = file_wdata;

    if (wb_acc_from_file) begin
        next_acc = file_rd; // [RQ2]
    end

    if (wb_acc_from_lit) begin
        next_acc = literal; // [RQ6]
    end

    if (wb_flag) begin
        next_zero_flag = (file_rd == `ZERO_BYTE); // [RQ4]
    end

    if (wb_setup) begin
        next_setup_reg = acc; // [RQ5]
    end

    if (wb_file_from_file) begin
        next_file_we    = 1'b1; // [RQ3]
        next_file_addr  = f_sel;
        next_file_wdata = file_rd;
    end

    if (wb_file_from_acc) begin
        next_file_we    = 1'b1; // [RQ6]
        next_file_addr  = f_sel;
        next_file_wdata = acc;
    end
end

// ----------------------------------------
// File write port
// ----------------------------------------
// Copy with d set rewrites the same value; harmless, and keeps one port
always @(posedge clk) begin
    if (clk_en && next_file_we) begin
        file_mem[next_file_addr] <= next_file_wdata; // [RQ3] [RQ6]
    end
end

// ----------------------------------------
// Architectural registers
// ----------------------------------------
// Reset values are a choice; only store and the setup copy depend on one, that of acc, if run before a load
always @(posedge clk or posedge reset) begin
    if (reset) begin
        acc <= `ACC_RESET;
    end else if (clk_en) begin
        acc <= next_acc; // [RQ2] [RQ6]
    end
end

always @(posedge clk or posedge reset) begin
    if (reset) begin
        setup_reg <= `SETUP_RESET;
    end else if (clk_en) begin
        setup_reg <= next_setup_reg; // [RQ5]
    end
end

always @(posedge clk or posedge reset) begin
    if (reset) begin
        zero_flag <= `FLAG_RESET;
    end else if (clk_en) begin
        zero_flag <= next_zero_flag; // [RQ4]
    end
end

// ----------------------------------------
// Write observation registers
// ----------------------------------------
// Held while clk_en is low, so a pulse is never lost during a freeze
always @(posedge clk or posedge reset) begin
    if (reset) begin
        file_we <= `FLAG_RESET;
    end else if (clk_en) begin
        file_we <= next_file_we;
    end
end

always @(posedge clk or posedge reset) begin
    if (reset) begin
        file_addr <= `ADDR_RESET;
    end else if (clk_en) begin
        file_addr <= next_file_addr;
    end
end

always @(posedge clk or posedge reset) begin
    if (reset) begin
        file_wdata <= `ZERO_BYTE;
    end else if (clk_en) begin
        file_wdata <= next_file_wdata;
    end
end

endmodule
